// [design/rof_regs.sv]
// serial-bus register bank: rail override / output levels and fault masks
// Overview of operation
// - bit 7 sets pin four, open-drain only
// - bits 6..4 set pins three, two, one
// - bit 3 forces termination LDO on
// - bit 2 forces load switch B two on
// - bit 1 forces load switch B one on
// - bit 0 forces LDO A three on
// - kill bit low forces rail off, wins
// - mask bit 7 ignores LDO A two faults
// - mask bit 6 ignores switch A one faults
// - mask bit 5 ignores step-down six faults
// - mask bit 4 ignores step-down five faults
// - mask bit 3 ignores step-down four faults
// - mask bit 2 ignores step-down three faults
// - mask bit 1 ignores step-down two faults
// - mask bit 0 ignores step-down one faults
// - mask register resets to its printed value
module rof_regs #(
   parameter logic [6:0] DEV_ADDR = rof_pkg::DEV_ADDR_DEFAULT,
   parameter logic [rof_pkg::GPO_W-1:0] OD_CFG = rof_pkg::OD_CFG_DEFAULT
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_N,
   input wire logic [rof_pkg::RAIL_W-1:0] RAIL_PIN_REQ,
   input wire logic [rof_pkg::RAIL_W-1:0] RAIL_KILL_N,
   input wire logic [rof_pkg::FAULT_W-1:0] RAIL_FAULT,
   input wire logic GPO_FOUR_ALT,
   output logic [rof_pkg::RAIL_W-1:0] RAIL_ON,
   output logic SHUTDOWN_REQ,
   output logic [rof_pkg::GPO_W-1:0] GPO_OUT,
   output logic [rof_pkg::GPO_W-1:0] GPO_OE_N
);
   // --------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------
   rof_pkg::rof_state_e state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] tx_reg, tx_next;
   logic [7:0] ptr_reg, ptr_next;
   logic rd_reg, rd_next;
   logic drv_reg, drv_next;
   logic [7:0] ovr_reg, ovr_next;
   logic [7:0] mask_reg, mask_next;
   logic scl_q_reg, sda_q_reg;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic [7:0] rd_byte;
   logic [7:0] in_byte;
   logic byte_done;
   logic bus_quiet;

   function automatic logic [7:0] rof_read(input logic [7:0] ptr, input logic [7:0] ovr,
                                           input logic [7:0] mask);
      logic [7:0] val;
      val = rof_pkg::READ_UNMAPPED;
      if (ptr == rof_pkg::OVR_ADDR) begin
         val = ovr;
      end else if (ptr == rof_pkg::MASK_ADDR) begin
         val = mask;
      end
      return val;
   endfunction

   // --------------------------------------------------------------------
   // bus condition detection
   // --------------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= SCL_IN;
         sda_q_reg <= SDA_IN;
      end
   end

   assign scl_rise = SCL_IN & ~scl_q_reg;
   assign scl_fall = ~SCL_IN & scl_q_reg;
   assign start_cond = scl_q_reg & SCL_IN & sda_q_reg & ~SDA_IN;
   assign stop_cond = scl_q_reg & SCL_IN & ~sda_q_reg & SDA_IN;
   assign in_byte = {shift_reg[6:0], SDA_IN};
   assign rd_byte = rof_read(ptr_reg, ovr_reg, mask_reg);
   assign byte_done = scl_rise && (cnt_reg == rof_pkg::LAST_BIT);
   // no start or stop this cycle, so the state case decides the next step
   assign bus_quiet = ~start_cond & ~stop_cond;

   // --------------------------------------------------------------------
   // protocol engine and register writes
   // --------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      ptr_next = ptr_reg;
      rd_next = rd_reg;
      drv_next = drv_reg;
      ovr_next = ovr_reg;
      mask_next = mask_reg;
      if (start_cond) begin
         state_next = rof_pkg::ST_ADDR;
         cnt_next = rof_pkg::CNT_ZERO;
         drv_next = 1'b0;
      end else if (stop_cond) begin
         state_next = rof_pkg::ST_IDLE;
         drv_next = 1'b0;
      end else begin
         case (state_reg)
            rof_pkg::ST_IDLE: begin
               drv_next = 1'b0;
            end
            rof_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift_next = in_byte;
                  cnt_next = cnt_reg + rof_pkg::CNT_ONE;
                  if (byte_done) begin
                     cnt_next = rof_pkg::CNT_ZERO;
                     rd_next = SDA_IN;
                     if (shift_reg[6:0] == DEV_ADDR) begin
                        state_next = rof_pkg::ST_ACK_ADDR;
                     end else begin
                        state_next = rof_pkg::ST_IDLE;
                     end
                  end
               end
            end
            rof_pkg::ST_ACK_ADDR: begin
               if (scl_fall) begin
                  if (!drv_reg) begin
                     drv_next = 1'b1;
                  end else if (rd_reg) begin
                     tx_next = rd_byte;
                     drv_next = ~rd_byte[7];
                     cnt_next = rof_pkg::CNT_ZERO;
                     state_next = rof_pkg::ST_RDATA;
                  end else begin
                     drv_next = 1'b0;
                     state_next = rof_pkg::ST_PTR;
                  end
               end
            end
            rof_pkg::ST_PTR, rof_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  shift_next = in_byte;
                  cnt_next = cnt_reg + rof_pkg::CNT_ONE;
                  if (byte_done) begin
                     cnt_next = rof_pkg::CNT_ZERO;
                     state_next = rof_pkg::ST_ACK_WR;
                     if (state_reg == rof_pkg::ST_PTR) begin
                        ptr_next = in_byte;
                     end else begin
                        // write lands on the eighth data bit, pins follow next cycle
                        if (ptr_reg == rof_pkg::OVR_ADDR) begin
                           ovr_next = in_byte;
                        end
                        if (ptr_reg == rof_pkg::MASK_ADDR) begin
                           mask_next = in_byte;
                        end
                        ptr_next = ptr_reg + rof_pkg::PTR_STEP;
                     end
                  end
               end
            end
            rof_pkg::ST_ACK_WR: begin
               if (scl_fall) begin
                  if (!drv_reg) begin
                     drv_next = 1'b1;
                  end else begin
                     drv_next = 1'b0;
                     state_next = rof_pkg::ST_WDATA;
                  end
               end
            end
            rof_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + rof_pkg::CNT_ONE;
                  if (byte_done) begin
                     cnt_next = rof_pkg::CNT_ZERO;
                     state_next = rof_pkg::ST_RACK;
                  end
               end else if (scl_fall) begin
                  tx_next = {tx_reg[6:0], 1'b0};
                  drv_next = ~tx_reg[6];
               end
            end
            rof_pkg::ST_RACK: begin
               if (scl_fall) begin
                  drv_next = 1'b0;
               end else if (scl_rise) begin
                  if (!SDA_IN) begin
                     ptr_next = ptr_reg + rof_pkg::PTR_STEP;
                     state_next = rof_pkg::ST_RNEXT;
                  end else begin
                     state_next = rof_pkg::ST_IDLE;
                  end
               end
            end
            rof_pkg::ST_RNEXT: begin
               if (scl_fall) begin
                  tx_next = rd_byte;
                  drv_next = ~rd_byte[7];
                  state_next = rof_pkg::ST_RDATA;
               end
            end
            default: begin
               state_next = rof_pkg::ST_IDLE;
               drv_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_reg <= rof_pkg::ST_IDLE;
         cnt_reg <= rof_pkg::CNT_ZERO;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rd_reg <= 1'b0;
         drv_reg <= 1'b0;
         ovr_reg <= rof_pkg::OVR_RESET;
         mask_reg <= rof_pkg::MASK_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         ptr_reg <= ptr_next;
         rd_reg <= rd_next;
         drv_reg <= drv_next;
         ovr_reg <= ovr_next;
         mask_reg <= mask_next;
      end
   end

   assign SDA_OUT = 1'b0;
   assign SDA_OE_N = ~drv_reg;

   // --------------------------------------------------------------------
   // rails, fault shutdown and general outputs
   // --------------------------------------------------------------------
   rof_rail_ctl u_rail (
      .clk(SYS_CLK),
      .rst(RST),
      .force_on(ovr_reg[rof_pkg::FORCE_LSB +: rof_pkg::RAIL_W]),
      .kill_n(RAIL_KILL_N),
      .pin_req(RAIL_PIN_REQ),
      .fault_ignore(mask_reg),
      .fault(RAIL_FAULT),
      .rail_on(RAIL_ON),
      .shutdown(SHUTDOWN_REQ)
   );

   rof_gpo_drv #(
      .OD_CFG(OD_CFG)
   ) u_gpo (
      .clk(SYS_CLK),
      .rst(RST),
      .level(ovr_reg[rof_pkg::LEVEL_LSB +: rof_pkg::GPO_W]),
      .alt_four(GPO_FOUR_ALT),
      .pin_out(GPO_OUT),
      .pin_oe_n(GPO_OE_N)
   );

   // --------------------------------------------------------------------
   // checks
   // --------------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   // --------------------------------------------------------------------
   // register checks
   // --------------------------------------------------------------------
   reset_values_a: assert property ($fell(RST) |-> ovr_reg == rof_pkg::OVR_RESET
      && mask_reg == rof_pkg::MASK_RESET)
      else $error("register reset value wrong");
   // pins settle two edges after the eighth data bit: register, then output flop
   ovr_write_a: assert property (state_reg == rof_pkg::ST_WDATA && byte_done && bus_quiet
      && ptr_reg == rof_pkg::OVR_ADDR |=> ovr_reg == $past(in_byte)
      ##1 RAIL_ON == (($past(ovr_reg[rof_pkg::FORCE_LSB +: rof_pkg::RAIL_W]) | $past(RAIL_PIN_REQ))
      & $past(RAIL_KILL_N)))
      else $error("override write not applied");
   mask_write_a: assert property (state_reg == rof_pkg::ST_WDATA && byte_done && bus_quiet
      && ptr_reg == rof_pkg::MASK_ADDR |=> mask_reg == $past(in_byte) && $stable(ovr_reg))
      else $error("mask write not applied");
   // registers move only at the eighth bit of a data byte
   regs_hold_a: assert property (state_reg != rof_pkg::ST_WDATA |=> $stable(ovr_reg) && $stable(mask_reg))
      else $error("register changed outside a write");
   wr_ptr_step_a: assert property (state_reg == rof_pkg::ST_WDATA && byte_done && bus_quiet
      |=> ptr_reg == $past(ptr_reg) + rof_pkg::PTR_STEP)
      else $error("pointer did not advance after a write");
   unmapped_read_a: assert property (ptr_reg != rof_pkg::OVR_ADDR && ptr_reg != rof_pkg::MASK_ADDR
      |-> rd_byte == rof_pkg::READ_UNMAPPED)
      else $error("unmapped pointer read not zero");

   // --------------------------------------------------------------------
   // bus protocol checks
   // --------------------------------------------------------------------
   start_restarts_a: assert property (start_cond |=> state_reg == rof_pkg::ST_ADDR
      && cnt_reg == rof_pkg::CNT_ZERO && SDA_OE_N)
      else $error("start did not restart the address phase");
   stop_release_a: assert property (stop_cond |=> state_reg == rof_pkg::ST_IDLE && SDA_OE_N)
      else $error("stop did not release the bus");
   wrong_addr_idle_a: assert property (state_reg == rof_pkg::ST_ADDR && byte_done && bus_quiet
      && shift_reg[6:0] != DEV_ADDR |=> state_reg == rof_pkg::ST_IDLE && SDA_OE_N)
      else $error("foreign address not ignored");
   addr_ack_a: assert property (state_reg == rof_pkg::ST_ACK_ADDR && scl_fall && !drv_reg && bus_quiet
      |=> !SDA_OE_N)
      else $error("address not acknowledged");
   ptr_load_a: assert property (state_reg == rof_pkg::ST_PTR && byte_done && bus_quiet
      |=> ptr_reg == $past(in_byte) && state_reg == rof_pkg::ST_ACK_WR)
      else $error("pointer byte not taken");
   wr_ack_a: assert property (state_reg == rof_pkg::ST_ACK_WR && scl_fall && !drv_reg && bus_quiet
      |=> !SDA_OE_N)
      else $error("written byte not acknowledged");
   // a released wire reads as one, so the active-low enable carries the bit itself
   rd_first_bit_a: assert property (state_reg == rof_pkg::ST_ACK_ADDR && scl_fall && drv_reg && rd_reg
      && bus_quiet |=> state_reg == rof_pkg::ST_RDATA && SDA_OE_N == $past(rd_byte[7]))
      else $error("first read bit wrong");
   rd_next_bit_a: assert property (state_reg == rof_pkg::ST_RDATA && scl_fall && bus_quiet
      |=> SDA_OE_N == $past(tx_reg[6]))
      else $error("read bit wrong");
   rd_ack_more_a: assert property (state_reg == rof_pkg::ST_RACK && scl_rise && !SDA_IN && bus_quiet
      |=> state_reg == rof_pkg::ST_RNEXT && ptr_reg == $past(ptr_reg) + rof_pkg::PTR_STEP)
      else $error("read continuation not taken");
   rd_nack_end_a: assert property (state_reg == rof_pkg::ST_RACK && scl_rise && SDA_IN && bus_quiet
      |=> state_reg == rof_pkg::ST_IDLE)
      else $error("read not ended on a refusal");

   // main scenarios: writes to both registers, single and burst reads, a shutdown
   wr_ovr_c: cover property (state_reg == rof_pkg::ST_WDATA && byte_done && ptr_reg == rof_pkg::OVR_ADDR);
   wr_mask_c: cover property (state_reg == rof_pkg::ST_WDATA && byte_done && ptr_reg == rof_pkg::MASK_ADDR);
   rd_more_c: cover property (state_reg == rof_pkg::ST_RACK && scl_rise && !SDA_IN);
   rd_byte_c: cover property (state_reg == rof_pkg::ST_RDATA ##[1:1000] state_reg == rof_pkg::ST_RACK);
   shutdown_c: cover property ($rose(SHUTDOWN_REQ));
endmodule // rof_regs

// [include/rof_pkg.sv]
// shared constants for the rail override and fault mask register block
package rof_pkg;
   // --------------------------------------------------------------------
   // register map
   // --------------------------------------------------------------------
   localparam logic [7:0] OVR_ADDR = 8'ha1;
   localparam logic [7:0] MASK_ADDR = 8'ha2;
   localparam logic [7:0] OVR_RESET = 8'h89;
   localparam logic [7:0] MASK_RESET = 8'hc0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // --------------------------------------------------------------------
   // field layout of the override / output level register
   // --------------------------------------------------------------------
   localparam int FORCE_LSB = 0;
   localparam int LEVEL_LSB = 4;
   localparam int RAIL_W = 4;
   localparam int GPO_W = 4;
   localparam int FAULT_W = 8;
   localparam int PIN_FOUR = 3;
   // --------------------------------------------------------------------
   // serial interface
   // --------------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5e;
   localparam logic [3:0] OD_CFG_DEFAULT = 4'hf;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [7:0] PTR_STEP = 8'h01;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_ADDR     = 9'h002,
      ST_ACK_ADDR = 9'h004,
      ST_PTR      = 9'h008,
      ST_WDATA    = 9'h010,
      ST_ACK_WR   = 9'h020,
      ST_RDATA    = 9'h040,
      ST_RACK     = 9'h080,
      ST_RNEXT    = 9'h100
   } rof_state_e;
endpackage

// [design/rof_rail_ctl.sv]
// rail enable resolution and fault shutdown gating
module rof_rail_ctl (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rof_pkg::RAIL_W-1:0] force_on,
   input wire logic [rof_pkg::RAIL_W-1:0] kill_n,
   input wire logic [rof_pkg::RAIL_W-1:0] pin_req,
   input wire logic [rof_pkg::FAULT_W-1:0] fault_ignore,
   input wire logic [rof_pkg::FAULT_W-1:0] fault,
   output logic [rof_pkg::RAIL_W-1:0] rail_on,
   output logic shutdown
);
   logic [rof_pkg::RAIL_W-1:0] on_reg, on_next;
   logic shut_reg, shut_next;

   // kill wins, then force, then pin or power-good request
   always_comb begin
      on_next = kill_n & (force_on | pin_req);
      shut_next = |(fault & ~fault_ignore);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         on_reg <= '0;
         shut_reg <= 1'b0;
      end else begin
         on_reg <= on_next;
         shut_reg <= shut_next;
      end
   end

   assign rail_on = on_reg;
   assign shutdown = shut_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   kill_forces_off_a: assert property (kill_n != '1 |=> (rail_on & ~$past(kill_n)) == '0)
      else $error("killed rail left on");
   force_turns_on_a: assert property (((force_on & kill_n) != '0) |=>
      (rail_on & $past(force_on & kill_n)) == $past(force_on & kill_n))
      else $error("forced rail not on");
   idle_follows_pin_a: assert property ((force_on == '0) |=> rail_on == $past(pin_req & kill_n))
      else $error("rail not following its request");
   fault_unmasked_a: assert property ((fault & ~fault_ignore) != '0 |=> shutdown)
      else $error("unmasked fault did not shut down");
   fault_masked_a: assert property ((fault & ~fault_ignore) == '0 |=> !shutdown)
      else $error("masked fault caused shutdown");
endmodule // rof_rail_ctl

// [design/rof_gpo_drv.sv]
// general output pin drivers, open-drain or push-pull per pin
module rof_gpo_drv #(
   parameter logic [rof_pkg::GPO_W-1:0] OD_CFG = rof_pkg::OD_CFG_DEFAULT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rof_pkg::GPO_W-1:0] level,
   input wire logic alt_four,
   output logic [rof_pkg::GPO_W-1:0] pin_out,
   output logic [rof_pkg::GPO_W-1:0] pin_oe_n
);
   logic [rof_pkg::GPO_W-1:0] out_reg, out_next;
   logic [rof_pkg::GPO_W-1:0] oe_n_reg, oe_n_next;
   logic [rof_pkg::GPO_W-1:0] lvl;

   always_comb begin
      lvl = level;
      // pin four takes the level bit only when wired open-drain
      if (!OD_CFG[rof_pkg::PIN_FOUR]) begin
         lvl[rof_pkg::PIN_FOUR] = alt_four;
      end
      out_next = lvl & ~OD_CFG;
      // open-drain: pull low for 0, release for 1; push-pull always drives
      oe_n_next = OD_CFG & lvl;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out_reg <= '0;
         oe_n_reg <= '1;
      end else begin
         out_reg <= out_next;
         oe_n_reg <= oe_n_next;
      end
   end

   assign pin_out = out_reg;
   assign pin_oe_n = oe_n_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   od_four_level_a: assert property (OD_CFG[rof_pkg::PIN_FOUR] |=>
      pin_oe_n[rof_pkg::PIN_FOUR] == $past(level[rof_pkg::PIN_FOUR]) && !pin_out[rof_pkg::PIN_FOUR])
      else $error("pin four level wrong");
   pin_level_a: assert property (1'b1 |=>
      ((pin_oe_n | pin_out) & 4'h7) == ($past(level) & 4'h7) && ((~OD_CFG & pin_oe_n) == '0))
      else $error("general output level wrong");
endmodule // rof_gpo_drv

// [verification/rof_host_model.sv]
// serial bus host model that drives the clock and pulls the data wire low
module rof_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------------------------------------------------------
   // bus phases, each step is four system clocks
   // --------------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic hold();
      repeat (4) @(negedge clk);
   endtask

   // serves as first and repeated start alike
   task automatic start();
      hold();
      sda_low = 1'b0;
      hold();
      scl = 1'b1;
      hold();
      sda_low = 1'b1;
      hold();
      scl = 1'b0;
   endtask

   task automatic stop();
      hold();
      sda_low = 1'b1;
      hold();
      scl = 1'b1;
      hold();
      sda_low = 1'b0;
   endtask

   task automatic put_bit(input logic b);
      hold();
      sda_low = ~b;
      hold();
      scl = 1'b1;
      hold();
      scl = 1'b0;
   endtask

   // wire released so the pull-up or the device decides the level
   task automatic get_bit(output logic b);
      hold();
      sda_low = 1'b0;
      hold();
      scl = 1'b1;
      hold();
      b = sda;
      scl = 1'b0;
   endtask

   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   // low on the ninth clock asks for one more byte
   task automatic byte_in(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(~more);
   endtask
endmodule // rof_host_model

// [verification/rof_regs_test.sv]
// self-checking testbench for the rail override and fault mask registers
module rof_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] OD = 4'h8;
   localparam logic [6:0] DEV = rof_pkg::DEV_ADDR_DEFAULT;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic four_alt = 1'b0;
   logic scl;
   logic sda_low;
   logic sda;
   logic sda_out;
   logic sda_oe_n;
   logic shutdown_req;
   logic [3:0] pin_req = 4'h0;
   logic [3:0] kill_n = 4'hf;
   logic [3:0] rail_on;
   logic [3:0] gpo_out;
   logic [3:0] gpo_oe_n;
   logic [7:0] fault = 8'h00;
   int fail_count = 0;
   int n_tests = 0;

   // open-drain wire with pull-up
   assign sda = ~sda_low & (sda_oe_n | sda_out);
   always #25 sys_clk = ~sys_clk;

   rof_host_model host (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   rof_regs #(.DEV_ADDR(DEV), .OD_CFG(OD)) uut (
      .SYS_CLK(sys_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .RAIL_PIN_REQ(pin_req), .RAIL_KILL_N(kill_n), .RAIL_FAULT(fault), .GPO_FOUR_ALT(four_alt),
      .RAIL_ON(rail_on), .SHUTDOWN_REQ(shutdown_req), .GPO_OUT(gpo_out), .GPO_OE_N(gpo_oe_n)
   );

   // --------------------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic settle();
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic do_reset();
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      settle();
   endtask

   task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
      logic a;
      host.start();
      host.byte_out({DEV, 1'b0}, a);
      chk({7'h00, a}, 8'h01);
      host.byte_out(ptr, a);
      chk({7'h00, a}, 8'h01);
      host.byte_out(d, a);
      chk({7'h00, a}, 8'h01);
      host.stop();
   endtask

   task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
      logic a;
      host.start();
      host.byte_out({DEV, 1'b0}, a);
      host.byte_out(ptr, a);
      host.start();
      host.byte_out({DEV, 1'b1}, a);
      host.byte_in(1'b0, d);
      host.stop();
   endtask

   // --------------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      pin_req = 4'h0;
      kill_n = 4'hf;
      fault = 8'h00;
      settle();
      chk({4'h0, rail_on}, 8'h09);
      chk({4'h0, gpo_oe_n}, 8'h08);
      chk({4'h0, gpo_out}, 8'h00);
      chk({7'h00, shutdown_req}, 8'h00);
      reg_rd(rof_pkg::OVR_ADDR, d);
      chk(d, 8'h89);
      reg_rd(rof_pkg::MASK_ADDR, d);
      chk(d, 8'hc0);
      fault = 8'hc0;
      settle();
      chk({7'h00, shutdown_req}, 8'h00);
      fault = 8'h01;
      settle();
      chk({7'h00, shutdown_req}, 8'h01);
      fault = 8'h00;
   endtask

   task automatic t_force();
      logic [3:0] kills [4] = '{4'hf, 4'h0, 4'h5, 4'ha};
      for (int i = 0; i < 4; i++) begin
         reg_wr(rof_pkg::OVR_ADDR, 8'h01 << i);
         chk({4'h0, rail_on}, 8'h01 << i);
      end
      reg_wr(rof_pkg::OVR_ADDR, 8'h0f);
      foreach (kills[k]) begin
         kill_n = kills[k];
         settle();
         chk({4'h0, rail_on}, {4'h0, kills[k]});
      end
      reg_wr(rof_pkg::OVR_ADDR, 8'h00);
      pin_req = 4'h5;
      kill_n = 4'hf;
      settle();
      chk({4'h0, rail_on}, 8'h05);
      pin_req = 4'hf;
      kill_n = 4'h6;
      settle();
      chk({4'h0, rail_on}, 8'h06);
      pin_req = 4'h0;
      kill_n = 4'hf;
   endtask

   task automatic t_levels();
      logic [7:0] v;
      for (int i = 0; i < 5; i++) begin
         v = 8'h10 << i;
         // open-drain pin four must ignore the alternate level
         four_alt = ~v[7];
         reg_wr(rof_pkg::OVR_ADDR, v);
         chk({4'h0, gpo_oe_n}, {4'h0, v[7], 3'h0});
         chk({4'h0, gpo_out}, {5'h00, v[6:4]});
      end
      four_alt = 1'b0;
   endtask

   task automatic t_mask();
      for (int i = 0; i < 8; i++) begin
         fault = 8'h01 << i;
         reg_wr(rof_pkg::MASK_ADDR, 8'h01 << i);
         chk({7'h00, shutdown_req}, 8'h00);
         reg_wr(rof_pkg::MASK_ADDR, ~(8'h01 << i));
         chk({7'h00, shutdown_req}, 8'h01);
      end
      fault = 8'h00;
   endtask

   task automatic t_burst();
      logic a;
      logic [7:0] d0;
      logic [7:0] d1;
      host.start();
      host.byte_out({DEV, 1'b0}, a);
      host.byte_out(rof_pkg::OVR_ADDR, a);
      host.byte_out(8'h5a, a);
      host.byte_out(8'h3c, a);
      host.stop();
      host.start();
      host.byte_out({DEV, 1'b0}, a);
      host.byte_out(rof_pkg::OVR_ADDR, a);
      host.start();
      host.byte_out({DEV, 1'b1}, a);
      host.byte_in(1'b1, d0);
      host.byte_in(1'b0, d1);
      host.stop();
      chk(d0, 8'h5a);
      chk(d1, 8'h3c);
      reg_rd(8'h00, d0);
      chk(d0, rof_pkg::READ_UNMAPPED);
      host.start();
      host.byte_out({DEV ^ 7'h01, 1'b0}, a);
      host.stop();
      chk({7'h00, a}, 8'h00);
   endtask

   // --------------------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------------------
   initial begin
      do_reset();
      t_reset();
      t_force();
      t_levels();
      t_mask();
      t_burst();
      do_reset();
      t_reset();
      print_verdict();
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end
endmodule // rof_regs_test
